// file: hw/dbc_defines.svh
`ifndef DBC_DEFINES_SVH
`define DBC_DEFINES_SVH

// register offsets (7-bit register space)
`define DBC_ADDR_W          7
`define DBC_REG_ACTION      7'h40
`define DBC_REG_STATE       7'h41
`define DBC_REG_LIMIT       7'h42
`define DBC_REG_COUNT       7'h43
`define DBC_REG_MIN_ON      7'h44
`define DBC_REG_MIN_OFF     7'h45
`define DBC_REG_TRIM        7'h46
`define DBC_REG_COMMAND     7'h47

// command / status field layout
`define DBC_PHASE_LSB       0
`define DBC_PHASE_MSB       3
`define DBC_SRC_BIT         4
`define DBC_CURR_LSB        5
`define DBC_CURR_MSB        6
`define DBC_TFLAG_BIT       7

// action register bits
`define DBC_ACT_REARM       0
`define DBC_ACT_LAUNCH      1
`define DBC_ACT_TCLR        2
`define DBC_ACT_CCLR        3

// trim register fields
`define DBC_VTRIM_LSB       0
`define DBC_VTRIM_MSB       2
`define DBC_DUTY_LSB        3
`define DBC_DUTY_MSB        5

// phase codes
`define DBC_PH_OFF          4'h0
`define DBC_PH_PRE1         4'h1
`define DBC_PH_PRE2         4'h2
`define DBC_PH_PRE12        4'h3
`define DBC_PH_FAST1        4'h4
`define DBC_PH_FAST2        4'h5
`define DBC_PH_PULS1        4'h6
`define DBC_PH_PULS2        4'h7
`define DBC_PH_F1P2         4'h8
`define DBC_PH_F2P1         4'h9
`define DBC_PH_U1P2         4'ha
`define DBC_PH_U2P1         4'hb
`define DBC_PH_LAST         4'hb

// per-battery mode encoding
`define DBC_MODE_OFF        2'h0
`define DBC_MODE_PRE        2'h1
`define DBC_MODE_FAST       2'h2
`define DBC_MODE_PULSE      2'h3

// timing
`define DBC_CLK_NS          50
`define DBC_TICK_NS         2000000
`define DBC_TICK_MS         2
`define DBC_UNIT_S          210
`define DBC_UNIT_TICKS      ((`DBC_UNIT_S * 1000) / `DBC_TICK_MS)
`define DBC_WDOG_TICKS      1000

// reset values
`define DBC_RST_BYTE        8'h00

`endif

// file: hw/dbc_pkg.sv
package dbc_pkg;

  // pulsed-charge gate states, one-hot
  typedef enum logic [1:0] {
    DBC_PS_ON  = 2'b01,
    DBC_PS_OFF = 2'b10
  } dbc_pstate_e;

  typedef struct packed {
    logic [3:0]  phase;
    logic        src;
    logic [1:0]  curr;
    logic [7:0]  limit;
    logic [7:0]  count;
    logic [16:0] unit;
    logic        run;
    logic        tim_flag;
    logic        chg_flag;
    logic [7:0]  min_on;
    logic [7:0]  min_off;
    logic [2:0]  vtrim;
    logic [2:0]  duty;
    dbc_pstate_e pstate;
    logic [7:0]  pcnt;
    logic [15:0] wdog;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        sync1;
    logic        sync2;
    logic [1:0]  bat1;
    logic [1:0]  bat2;
  } dbc_state_s;

endpackage

// file: hw/dbc_tick_gen.sv
`timescale 1ns/1ps
`include "dbc_defines.svh"

module dbc_tick_gen #(
  parameter int TICK_CYC = `DBC_TICK_NS / `DBC_CLK_NS
) (
  // clock, reset and enable
  input  wire logic I_CLK,
  input  wire logic I_RST_N,
  input  wire logic I_CE,
  // time base
  output logic      o_tick
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        tick_ff;
  logic        nxt_tick;

  // free running divider, one pulse per period
  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt  = cnt_ff + 32'h1;
    if (cnt_ff >= 32'(TICK_CYC - 1)) begin
      nxt_cnt  = 32'h0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end else if (I_CE) begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff & I_CE;

endmodule

// file: hw/dbc_charge_ctrl.sv
`timescale 1ns/1ps
`include "dbc_defines.svh"

module dbc_charge_ctrl #(
  parameter int TICK_CYC   = `DBC_TICK_NS / `DBC_CLK_NS,
  parameter int WDOG_TICKS = `DBC_WDOG_TICKS,
  parameter int UNIT_TICKS = `DBC_UNIT_TICKS
) (
  // clock, reset, enable
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST_N,
  input  wire logic                   I_CE,
  // register port
  input  wire logic                   I_WR_EN,
  input  wire logic                   I_RD_EN,
  input  wire logic [`DBC_ADDR_W-1:0] I_ADDR,
  input  wire logic [7:0]             I_WDATA,
  output logic      [7:0]             O_RDATA,
  output logic                        O_RVALID,
  // charger pins
  input  wire logic                   I_CHARGE_SUSPEND_IN,
  output logic                        O_IRQ_N_OUT,
  // analogue charger controls
  output logic      [1:0]             O_BAT1_MODE,
  output logic      [1:0]             O_BAT2_MODE,
  output logic                        O_PULSE_GATE,
  output logic                        O_SRC_USB,
  output logic      [1:0]             O_CURRENT_CODE,
  output logic      [2:0]             O_VOLTAGE_CODE,
  output logic      [2:0]             O_DUTY_CODE
);

  dbc_pkg::dbc_state_s st_ff;
  dbc_pkg::dbc_state_s nxt_st;
  logic                tick;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // phase code to per-battery modes {bat2, bat1}
  function automatic logic [3:0] phase_modes(input logic [3:0] ph);
    logic [3:0] m;
    m = {`DBC_MODE_OFF, `DBC_MODE_OFF};
    case (ph)
      `DBC_PH_PRE1:  m = {`DBC_MODE_OFF, `DBC_MODE_PRE};
      `DBC_PH_PRE2:  m = {`DBC_MODE_PRE, `DBC_MODE_OFF};
      `DBC_PH_PRE12: m = {`DBC_MODE_PRE, `DBC_MODE_PRE};
      `DBC_PH_FAST1: m = {`DBC_MODE_OFF, `DBC_MODE_FAST};
      `DBC_PH_FAST2: m = {`DBC_MODE_FAST, `DBC_MODE_OFF};
      `DBC_PH_PULS1: m = {`DBC_MODE_OFF, `DBC_MODE_PULSE};
      `DBC_PH_PULS2: m = {`DBC_MODE_PULSE, `DBC_MODE_OFF};
      `DBC_PH_F1P2:  m = {`DBC_MODE_PRE, `DBC_MODE_FAST};
      `DBC_PH_F2P1:  m = {`DBC_MODE_FAST, `DBC_MODE_PRE};
      `DBC_PH_U1P2:  m = {`DBC_MODE_PRE, `DBC_MODE_PULSE};
      `DBC_PH_U2P1:  m = {`DBC_MODE_PULSE, `DBC_MODE_PRE};
      default:       m = {`DBC_MODE_OFF, `DBC_MODE_OFF};
    endcase
    return m;
  endfunction

  // status byte in command layout plus expiry flag
  function automatic logic [7:0] status_byte(input dbc_pkg::dbc_state_s s);
    logic [7:0] b;
    b = `DBC_RST_BYTE;
    b[`DBC_PHASE_MSB:`DBC_PHASE_LSB] = s.phase;
    b[`DBC_SRC_BIT]                  = s.src;
    b[`DBC_CURR_MSB:`DBC_CURR_LSB]   = s.curr;
    b[`DBC_TFLAG_BIT] = s.tim_flag & (s.limit != 8'h00);
    return b;
  endfunction

  // status byte as a net, so checks can pick bits from it
  logic [7:0] status_now;
  assign status_now = status_byte(st_ff);

  ////////////////////////////////////////////////////////////////////////////
  // 2 ms time base

  dbc_tick_gen #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .I_CLK   (I_CLK),
    .I_RST_N (I_RST_N),
    .I_CE    (I_CE),
    .o_tick  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic       wr_cmd;
  logic       wr_act;
  logic       wr_lim;
  logic       pulsing;
  logic       unit_done;
  logic       expire;
  logic       wdog_bite;
  logic [3:0] modes;

  always_comb begin
    nxt_st    = st_ff;
    wr_cmd    = I_WR_EN && (I_ADDR == `DBC_REG_COMMAND);
    wr_act    = I_WR_EN && (I_ADDR == `DBC_REG_ACTION);
    wr_lim    = I_WR_EN && (I_ADDR == `DBC_REG_LIMIT);
    unit_done = 1'b0;
    expire    = 1'b0;
    wdog_bite = 1'b0;
    modes     = 4'h0;
    pulsing   = 1'b0;

    // suspend pin synchroniser
    nxt_st.sync1 = I_CHARGE_SUSPEND_IN;
    nxt_st.sync2 = st_ff.sync1;

    // command register, unused codes stored as off
    if (wr_cmd) begin
      if (I_WDATA[`DBC_PHASE_MSB:`DBC_PHASE_LSB] > `DBC_PH_LAST) begin
        nxt_st.phase = `DBC_PH_OFF;
      end else begin
        nxt_st.phase = I_WDATA[`DBC_PHASE_MSB:`DBC_PHASE_LSB];
      end
      nxt_st.src  = I_WDATA[`DBC_SRC_BIT];
      nxt_st.curr = I_WDATA[`DBC_CURR_MSB:`DBC_CURR_LSB];
    end

    // plain settings registers
    if (I_WR_EN && (I_ADDR == `DBC_REG_MIN_ON)) begin
      nxt_st.min_on = I_WDATA;
    end
    if (I_WR_EN && (I_ADDR == `DBC_REG_MIN_OFF)) begin
      nxt_st.min_off = I_WDATA;
    end
    if (I_WR_EN && (I_ADDR == `DBC_REG_TRIM)) begin
      nxt_st.vtrim = I_WDATA[`DBC_VTRIM_MSB:`DBC_VTRIM_LSB];
      nxt_st.duty  = I_WDATA[`DBC_DUTY_MSB:`DBC_DUTY_LSB];
    end

    // safety limit, zero stops the timer
    if (wr_lim) begin
      nxt_st.limit = I_WDATA;
      if (I_WDATA == 8'h00) begin
        nxt_st.run = 1'b0;
      end
    end

    // safety timer, counts 210 s units while running
    if (st_ff.run && tick) begin
      if (st_ff.unit == 17'(UNIT_TICKS - 1)) begin
        nxt_st.unit = 17'h0;
        unit_done   = 1'b1;
      end else begin
        nxt_st.unit = st_ff.unit + 17'h1;
      end
    end
    if (unit_done) begin
      nxt_st.count = st_ff.count + 8'h1;
      if ((st_ff.count + 8'h1) >= st_ff.limit) begin
        expire     = st_ff.limit != 8'h00;
        nxt_st.run = 1'b0;
      end
    end

    // launch restarts from zero
    if (wr_act && I_WDATA[`DBC_ACT_LAUNCH] && !expire) begin
      nxt_st.run   = (wr_lim ? I_WDATA : st_ff.limit) != 8'h00;
      nxt_st.count = 8'h00;
      nxt_st.unit  = 17'h0;
    end

    // watchdog, counts ticks only while charging
    if (wr_act && I_WDATA[`DBC_ACT_REARM]) begin
      nxt_st.wdog = 16'h0;
    end else if (st_ff.phase == `DBC_PH_OFF) begin
      nxt_st.wdog = 16'h0;
    end else if (tick) begin
      if (st_ff.wdog >= 16'(WDOG_TICKS - 1)) begin
        wdog_bite   = 1'b1;
        nxt_st.wdog = 16'h0;
      end else begin
        nxt_st.wdog = st_ff.wdog + 16'h1;
      end
    end

    // interrupt flags, set wins over clear
    nxt_st.tim_flag = (st_ff.tim_flag & ~(wr_act & I_WDATA[`DBC_ACT_TCLR])) | expire;
    nxt_st.chg_flag = (st_ff.chg_flag & ~(wr_act & I_WDATA[`DBC_ACT_CCLR])) | wdog_bite;

    // expiry or watchdog bite ends charging
    if (expire || wdog_bite) begin
      nxt_st.phase = `DBC_PH_OFF;
    end

    // battery modes, suspended by pin
    modes = phase_modes(nxt_st.phase);
    if (st_ff.sync2) begin
      modes = {`DBC_MODE_OFF, `DBC_MODE_OFF};
    end
    nxt_st.bat1 = modes[1:0];
    nxt_st.bat2 = modes[3:2];
    pulsing = (st_ff.bat1 == `DBC_MODE_PULSE) || (st_ff.bat2 == `DBC_MODE_PULSE);

    // pulsed charge on/off minimum intervals
    if (!pulsing) begin
      nxt_st.pstate = dbc_pkg::DBC_PS_ON;
      nxt_st.pcnt   = 8'h00;
    end else if (tick) begin
      case (st_ff.pstate)
        dbc_pkg::DBC_PS_ON: begin
          if (st_ff.pcnt >= st_ff.min_on) begin
            nxt_st.pstate = dbc_pkg::DBC_PS_OFF;
            nxt_st.pcnt   = 8'h00;
          end else begin
            nxt_st.pcnt = st_ff.pcnt + 8'h1;
          end
        end
        dbc_pkg::DBC_PS_OFF: begin
          if (st_ff.pcnt >= st_ff.min_off) begin
            nxt_st.pstate = dbc_pkg::DBC_PS_ON;
            nxt_st.pcnt   = 8'h00;
          end else begin
            nxt_st.pcnt = st_ff.pcnt + 8'h1;
          end
        end
        default: begin
          nxt_st.pstate = dbc_pkg::DBC_PS_ON;
          nxt_st.pcnt   = 8'h00;
        end
      endcase
    end

    // register read port, one cycle latency
    nxt_st.rvalid = I_RD_EN;
    if (I_RD_EN) begin
      case (I_ADDR)
        `DBC_REG_STATE:   nxt_st.rdata = status_now;
        `DBC_REG_COUNT:   nxt_st.rdata = st_ff.count;
        `DBC_REG_MIN_ON:  nxt_st.rdata = st_ff.min_on;
        `DBC_REG_MIN_OFF: nxt_st.rdata = st_ff.min_off;
        `DBC_REG_TRIM:    nxt_st.rdata = {2'h0, st_ff.duty, st_ff.vtrim};
        default:          nxt_st.rdata = `DBC_RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_ff        <= '0;
      st_ff.pstate <= dbc_pkg::DBC_PS_ON;
    end else if (I_CE) begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign O_RDATA        = st_ff.rdata;
  assign O_RVALID       = st_ff.rvalid;
  assign O_IRQ_N_OUT    = ~(st_ff.tim_flag | st_ff.chg_flag);
  assign O_BAT1_MODE    = st_ff.bat1;
  assign O_BAT2_MODE    = st_ff.bat2;
  assign O_PULSE_GATE   = st_ff.pstate == dbc_pkg::DBC_PS_ON;
  assign O_SRC_USB      = st_ff.src;
  assign O_CURRENT_CODE = st_ff.curr;
  assign O_VOLTAGE_CODE = st_ff.vtrim;
  assign O_DUTY_CODE    = st_ff.duty;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence cmd_write_s;
    I_CE && I_WR_EN && (I_ADDR == `DBC_REG_COMMAND);
  endsequence

  sequence no_kill_s;
    !expire && !wdog_bite;
  endsequence

  unused_code_a: assert property (
    (cmd_write_s and no_kill_s) ##0 (I_WDATA[`DBC_PHASE_MSB:`DBC_PHASE_LSB] > `DBC_PH_LAST)
    |=> (st_ff.phase == `DBC_PH_OFF))
    else $error("unused phase code not forced off");

  cmd_store_a: assert property (
    (cmd_write_s and no_kill_s) ##0 (I_WDATA[`DBC_PHASE_MSB:`DBC_PHASE_LSB] <= `DBC_PH_LAST)
    |=> (status_now[`DBC_CURR_MSB:`DBC_PHASE_LSB] == $past(I_WDATA[`DBC_CURR_MSB:`DBC_PHASE_LSB])))
    else $error("status does not reflect command");

  irq_pin_a: assert property (
    I_CE && (expire || wdog_bite) |=> (O_IRQ_N_OUT == 1'b0))
    else $error("interrupt pin not low after interrupt event");

  expiry_off_a: assert property (
    $rose(st_ff.tim_flag) |-> (st_ff.phase == `DBC_PH_OFF) && (O_IRQ_N_OUT == 1'b0))
    else $error("expiry did not end charging");

  timer_clear_a: assert property (
    I_CE && wr_act && I_WDATA[`DBC_ACT_TCLR] && !expire |=> !st_ff.tim_flag)
    else $error("timer interrupt not cleared");

  disabled_flag_a: assert property (
    (st_ff.limit == 8'h00) |-> !status_now[`DBC_TFLAG_BIT] && !st_ff.run && !expire)
    else $error("timer flag with timer disabled");

  suspend_off_a: assert property (
    I_CE && st_ff.sync2 |=> (O_BAT1_MODE == `DBC_MODE_OFF) && (O_BAT2_MODE == `DBC_MODE_OFF))
    else $error("charging while suspended");

  launch_zero_a: assert property (
    I_CE && wr_act && I_WDATA[`DBC_ACT_LAUNCH] && !expire && !wr_lim && (st_ff.limit != 8'h00)
    |=> st_ff.run && (st_ff.count == 8'h00))
    else $error("launch did not restart timer");

  pulse_on_a: assert property (
    I_CE && (st_ff.pstate == dbc_pkg::DBC_PS_ON) && pulsing ##1 (st_ff.pstate == dbc_pkg::DBC_PS_OFF)
    |-> $past(st_ff.pcnt) >= $past(st_ff.min_on))
    else $error("pulse on interval too short");

endmodule

// file: verif/dbc_host_model.sv
`timescale 1ns/1ps

module dbc_host_model (
  // clock
  input  wire logic       I_CLK,
  // register port
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic [6:0]      o_addr,
  output logic [7:0]      o_wdata,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  // idle bus at time zero
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 7'h00;
    o_wdata = 8'h00;
  end

  // one-cycle write strobe, bus scrambled after release
  task automatic wr(input logic [6:0] a, input logic [7:0] dat);
    @(posedge I_CLK);
    o_wr_en <= 1'b1;
    o_addr  <= a;
    o_wdata <= dat;
    @(posedge I_CLK);
    o_wr_en <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~dat;
  endtask

  // one-cycle read strobe, data taken with the valid pulse
  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    @(posedge I_CLK);
    o_rd_en <= 1'b1;
    o_addr  <= a;
    @(posedge I_CLK);
    o_rd_en <= 1'b0;
    o_addr  <= ~a;
    q = 8'hxx;
    repeat (4) begin
      @(posedge I_CLK);
      if (i_rvalid === 1'b1) begin
        q = i_rdata;
        break;
      end
    end
  endtask

  // processor keeps the charger watchdog fed
  task automatic rearm;
    wr(7'h40, 8'h01);
  endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end

module tb;
  logic       clk;
  logic       rst_n;
  logic       ce;
  logic       suspend;
  logic       wr_en;
  logic       rd_en;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       irq_n;
  logic [1:0] bat1;
  logic [1:0] bat2;
  logic       gate;
  logic       usb;
  logic [1:0] curr;
  logic [2:0] vcode;
  logic [2:0] dcode;
  logic [7:0] d;
  int         bad_count;
  int         checked;
  int         n;
  int         el;
  time        t0;

  // expected {bat2, bat1} per phase code
  localparam logic [3:0] MODES [16] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h2, 4'h8, 4'h3, 4'hc,
                                        4'h6, 4'h9, 4'h7, 4'hd, 4'h0, 4'h0, 4'h0, 4'h0};

  // short tick, timer unit and watchdog so the run stays brief
  dbc_charge_ctrl #(.TICK_CYC(4), .WDOG_TICKS(64), .UNIT_TICKS(105)) dut_u (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr),
    .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid), .I_CHARGE_SUSPEND_IN(suspend),
    .O_IRQ_N_OUT(irq_n), .O_BAT1_MODE(bat1), .O_BAT2_MODE(bat2), .O_PULSE_GATE(gate), .O_SRC_USB(usb),
    .O_CURRENT_CODE(curr), .O_VOLTAGE_CODE(vcode), .O_DUTY_CODE(dcode));

  dbc_host_model host_u (
    .I_CLK(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata),
    .i_rdata(rdata), .i_rvalid(rvalid));

  // clock generator
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // k edges, then settle
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // idle with periodic rearm
  task automatic wait_arm(input int k);
    repeat (k) begin
      tick(100);
      host_u.rearm();
    end
  endtask

  // cycles the pulse gate stays at lvl
  task automatic level(input logic lvl, output int k);
    k = 0;
    while (gate === lvl && k < 1000) begin
      tick(1);
      k++;
    end
  endtask

  task automatic t_reset;
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("gate", 1'b1, gate)
    `CHK("modes", 4'h0, {bat2, bat1})
    host_u.wr(7'h41, 8'hff);
    host_u.rd(7'h41, d);
    `CHK("status", 8'h00, d)
    host_u.rd(7'h40, d);
    `CHK("action_rd", 8'h00, d)
    host_u.rd(7'h10, d);
    `CHK("unmapped", 8'h00, d)
    host_u.rd(7'h44, d);
    `CHK("min_on_rst", 8'h00, d)
    $display("test reset done");
  endtask

  // enable low: a command write must be ignored
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    host_u.wr(7'h47, 8'h04);
    tick(3);
    `CHK("frozen_bat1", 2'h0, bat1)
    `CHK("frozen_irq", 1'b1, irq_n)
    @(posedge clk);
    ce <= 1'b1;
    host_u.rd(7'h41, d);
    `CHK("frozen_status", 8'h00, d)
    $display("test freeze done");
  endtask

  task automatic t_phase;
    for (int i = 0; i < 16; i++) begin
      host_u.rearm();
      host_u.wr(7'h47, {1'b0, i[1:0], i[0], i[3:0]});
      tick(1);
      `CHK("modes", MODES[i], {bat2, bat1})
      `CHK("usb", i[0], usb)
      `CHK("curr", i[1:0], curr)
      host_u.rd(7'h41, d);
      `CHK("status", {1'b0, i[1:0], i[0], (i < 12) ? i[3:0] : 4'h0}, d)
    end
    $display("test phase done");
  endtask

  task automatic t_trim;
    for (int v = 0; v < 8; v++) begin
      host_u.wr(7'h46, {2'b11, ~v[2:0], v[2:0]});
      tick(1);
      `CHK("vcode", v[2:0], vcode)
      `CHK("duty", ~v[2:0], dcode)
      host_u.rd(7'h46, d);
      `CHK("trim_rd", {2'b00, ~v[2:0], v[2:0]}, d)
    end
    $display("test trim done");
  endtask

  task automatic t_pulse;
    host_u.wr(7'h44, 8'h02);
    host_u.wr(7'h45, 8'h01);
    host_u.rd(7'h45, d);
    `CHK("min_off_rd", 8'h01, d)
    host_u.rearm();
    host_u.wr(7'h47, 8'h06);
    tick(1);
    `CHK("bat1", 2'h3, bat1)
    level(1'b1, n);
    level(1'b0, n);
    `CHK("off_len", 8, n)
    level(1'b1, n);
    `CHK("on_len", 12, n)
    host_u.wr(7'h47, 8'h00);
    tick(1);
    `CHK("gate_idle", 1'b1, gate)
    $display("test pulse done");
  endtask

  task automatic t_suspend;
    host_u.rearm();
    host_u.wr(7'h47, 8'h04);
    @(posedge clk);
    suspend <= 1'b1;
    tick(2);
    `CHK("bat1_early", 2'h2, bat1)
    tick(1);
    `CHK("bat1_susp", 2'h0, bat1)
    host_u.rd(7'h41, d);
    `CHK("status_susp", 8'h04, d)
    @(posedge clk);
    suspend <= 1'b0;
    tick(4);
    `CHK("bat1_back", 2'h2, bat1)
    host_u.wr(7'h47, 8'h00);
    $display("test suspend done");
  endtask

  task automatic t_timer;
    host_u.wr(7'h42, 8'h01);
    host_u.wr(7'h40, 8'h02);
    t0 = $time;
    host_u.wr(7'h47, 8'h04);
    wait_arm(3);
    host_u.rd(7'h43, d);
    `CHK("count_early", 8'h00, d)
    `CHK("irq_early", 1'b1, irq_n)
    n = 0;
    while (irq_n !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    el = int'(($time - t0) / 50);
    `CHK("expiry_at", 1'b1, el >= 414 && el <= 430)
    `CHK("bat1_off", 2'h0, bat1)
    host_u.rd(7'h43, d);
    `CHK("count_end", 8'h01, d)
    host_u.rd(7'h41, d);
    `CHK("status_exp", 8'h80, d)
    host_u.wr(7'h40, 8'h08);
    tick(1);
    `CHK("irq_held", 1'b0, irq_n)
    host_u.wr(7'h40, 8'h04);
    tick(1);
    `CHK("irq_clr", 1'b1, irq_n)
    host_u.rd(7'h41, d);
    `CHK("status_clr", 8'h00, d)
    // disabled timer never expires
    host_u.wr(7'h42, 8'h00);
    host_u.wr(7'h40, 8'h02);
    host_u.wr(7'h47, 8'h04);
    wait_arm(5);
    `CHK("irq_dis", 1'b1, irq_n)
    host_u.rd(7'h41, d);
    `CHK("status_dis", 8'h04, d)
    host_u.wr(7'h47, 8'h00);
    $display("test timer done");
  endtask

  task automatic t_wdog;
    host_u.rearm();
    host_u.wr(7'h47, 8'h04);
    tick(230);
    `CHK("wd_early", 2'h2, bat1)
    tick(40);
    `CHK("wd_bite", 2'h0, bat1)
    `CHK("wd_irq", 1'b0, irq_n)
    host_u.wr(7'h40, 8'h00);
    tick(1);
    `CHK("wd_zero", 1'b0, irq_n)
    host_u.wr(7'h40, 8'h08);
    tick(1);
    `CHK("wd_clr", 1'b1, irq_n)
    $display("test watchdog done");
  endtask

  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    #1000000;
    bad_count++;
    summarize();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    suspend = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_freeze();
    t_phase();
    t_trim();
    t_pulse();
    t_suspend();
    t_timer();
    t_wdog();
    summarize();
  end
endmodule
